// >>> rtl/swc_params.svh
// sleep/wake control constants: offsets, field positions, resets, timing.
// assumes inclusion by bare name from the swc package and design modules.
`ifndef SWC_PARAMS_SVH
`define SWC_PARAMS_SVH
`define SWC_OFF_CTRL 12'h000
`define SWC_OFF_STAT 12'h004
`define SWC_OFF_IRQ 12'h008
`define SWC_OFF_MASK 12'h00C
`define SWC_OFF_CNT 12'h010
`define SWC_CTRL_WATCHDOG_EN 0
`define SWC_CTRL_RC_MODE 1
`define SWC_CTRL_IRQ_EN 2
`define SWC_CTRL_RESET 32'h0000_0000
`define SWC_STAT_TIMEOUT 0
`define SWC_STAT_POWERDOWN 1
`define SWC_STAT_ASLEEP 2
`define SWC_STAT_WAITING 3
`define SWC_IRQ_ENTER 0
`define SWC_IRQ_NOP 1
`define SWC_IRQ_WAKE_INT 2
`define SWC_IRQ_WAKE_WATCHDOG 3
`define SWC_NUM_SRC 11
`define SWC_VECTOR 16'h0004
`define SWC_STARTUP_PERIODS 1024
`define SWC_OSC_PER_CYCLE 1
`define SWC_STARTUP_CYCLES (`SWC_STARTUP_PERIODS * `SWC_OSC_PER_CYCLE)
`endif

// >>> rtl/swc_pkg.sv
// types for the sleep/wake control block.
// assumes swc_params.svh sits beside this package.
`include "swc_params.svh"
package swc_pkg;
	typedef logic [`SWC_NUM_SRC-1:0] swc_src_t;
	typedef logic [15:0] swc_pc_t;
	// gray along run -> sleep -> startup -> resume
	typedef enum logic [1:0] {
		SWC_RUN = 2'b00,
		SWC_SLEEP = 2'b01,
		SWC_STARTUP = 2'b11,
		SWC_RESUME = 2'b10
	} swc_state_t;
	typedef enum logic [1:0] {
		SWC_GO_NONE = 2'b00,
		SWC_GO_NEXT = 2'b01,
		SWC_GO_VECTOR = 2'b11
	} swc_resume_t;
endpackage

// >>> rtl/swc_wake_if.sv
// wake-detect bundle between the sequencer and the wake combiner.
// assumes one clock domain, driven by the sequencer.
`timescale 1ns/10ps
interface swc_wake_if;
	import swc_pkg::*;
	swc_src_t flag;
	swc_src_t enable;
	logic int_pin;
	logic int_pin_en;
	logic port_chg;
	logic port_chg_en;
	logic wake_req;
	modport seq(output flag, enable, int_pin, int_pin_en, port_chg,
		port_chg_en, input wake_req);
	modport comb(input flag, enable, int_pin, int_pin_en, port_chg,
		port_chg_en, output wake_req);
endinterface

// >>> rtl/swc_wake_comb.sv
// wake combiner: enable-and-flag per source, no clock used.
// assumes flags come straight from the peripherals' own latches.
`timescale 1ns/10ps
module swc_wake_comb (
	swc_wake_if.comb w
);
	import swc_pkg::*;
	// purely combinational so it works with the core clock stopped
	always_comb begin
		w.wake_req = (|(w.flag & w.enable))
			| (w.int_pin & w.int_pin_en) | (w.port_chg & w.port_chg_en);
	end
endmodule

// >>> rtl/swc_top.sv
// sleep/wake sequencer with an axi4-lite register slave.
// assumes synchronous reset and peripheral flags synchronous to clock_in.
//
// Added by the designer: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "swc_params.svh"
// Functional notes
// - wake on reset pin, watchdog, interrupts
// - only reset pin resets; others continue
// - powerdown flag set at power-up, cleared
// - timeout flag cleared by watchdog wake
// - only listed peripheral sources may wake
// - other peripherals cannot raise wake
// - prefetch pc plus one during sleep
// - wake needs source enable, ignores global enable
// - global enable off continues; on vectors 0004h
// - pending enabled flag makes sleep nop
// - late interrupt: finish sleep, wake now
// - startup delay 1024 periods, none rc
// - sleep clears watchdog, sets flags, stops osc
// - enter sleep only by sleep instruction
module swc_top (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// core interface
	input wire logic sleep_instr_in,
	input wire logic watchdog_clear_instr_in,
	input wire swc_pkg::swc_pc_t pc_in,
	input wire logic external_reset_pin_n_in,
	input wire logic watchdog_timeout_in,
	// wake sources
	input wire swc_pkg::swc_src_t periph_flag_in,
	input wire swc_pkg::swc_src_t periph_enable_in,
	input wire logic int_pin_flag_in,
	input wire logic int_pin_enable_in,
	input wire logic port_b_change_in,
	input wire logic port_b_change_enable_in,
	// control outputs
	output logic core_reset_out,
	output logic clock_run_out,
	output logic osc_enable_out,
	output logic io_hold_out,
	output logic watchdog_clear_out,
	output logic sleep_nop_out,
	output logic resume_out,
	output logic vector_out,
	output swc_pkg::swc_pc_t fetch_addr_out,
	output logic timeout_flag_out,
	output logic powerdown_flag_out,
	output logic irq_out,
	// axi4-lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import swc_pkg::*;

	localparam logic [10:0] STARTUP_LAST = 11'(`SWC_STARTUP_CYCLES - 1);
	localparam swc_src_t WAKE_CAPABLE = 11'h7FF;

	function automatic logic [1:0] okay_or_slverr(input logic hit);
		okay_or_slverr = hit ? 2'h0 : 2'h2;
	endfunction

	function automatic logic addr_hit(input logic [11:0] a);
		addr_hit = (a == `SWC_OFF_CTRL) || (a == `SWC_OFF_STAT) ||
			(a == `SWC_OFF_IRQ) || (a == `SWC_OFF_MASK) ||
			(a == `SWC_OFF_CNT);
	endfunction

	swc_wake_if wk();
	swc_wake_comb u_comb (
		.w(wk.comb)
	);
	// only clock-independent sources are wired to wake logic
	assign wk.flag = periph_flag_in & WAKE_CAPABLE;
	assign wk.enable = periph_enable_in;
	assign wk.int_pin = int_pin_flag_in;
	assign wk.int_pin_en = int_pin_enable_in;
	assign wk.port_chg = port_b_change_in;
	assign wk.port_chg_en = port_b_change_enable_in;

	// state
	swc_state_t state_reg, state_next;
	logic [10:0] startup_cnt_reg, startup_cnt_next;
	logic to_reg, to_next, powerdown_reg, powerdown_next;
	logic wdog_wake_reg, wdog_wake_next;
	logic run_reg, run_next, osc_reg, osc_next;
	logic hold_reg, hold_next;
	logic awrdy_reg, awrdy_next, wrdy_reg, wrdy_next;
	logic ardy_reg, ardy_next;
	logic core_rst_reg, core_rst_next;
	logic wclr_reg, wclr_next, nop_reg, nop_next;
	logic resume_reg, resume_next, vector_reg, vector_next;
	swc_pc_t fetch_reg, fetch_next;
	logic [31:0] ctrl_reg, ctrl_next;
	logic [3:0] irq_reg, irq_next, mask_reg, mask_next;
	logic irq_out_reg, irq_out_next;
	logic aw_reg, aw_next, w_reg, w_next;
	logic [11:0] awa_reg, awa_next;
	logic [31:0] wd_reg, wd_next;
	logic [3:0] ws_reg, ws_next;
	logic bv_reg, bv_next, rv_reg, rv_next;
	logic [1:0] br_reg, br_next, rr_reg, rr_next;
	logic [31:0] rd_reg, rd_next;
	logic [3:0] ev;
	logic wr_go, rd_go, ctrl_wr;

	assign wr_go = aw_reg && w_reg && !bv_reg;
	assign rd_go = s_axi_arvalid && !rv_reg;
	assign ctrl_wr = wr_go && (awa_reg == `SWC_OFF_CTRL);

	always_comb begin
		state_next = state_reg;
		startup_cnt_next = startup_cnt_reg;
		to_next = to_reg;
		powerdown_next = powerdown_reg;
		wdog_wake_next = wdog_wake_reg;
		core_rst_next = 1'b0;
		wclr_next = 1'b0;
		nop_next = 1'b0;
		resume_next = 1'b0;
		vector_next = 1'b0;
		fetch_next = fetch_reg;
		ev = 4'h0;
		if (!external_reset_pin_n_in) begin
			// full reset from the pin only, from any state
			state_next = SWC_RUN;
			core_rst_next = 1'b1;
			to_next = 1'b1;
			powerdown_next = 1'b1;
		end else begin
			unique case (state_reg)
				SWC_RUN: begin
					if (watchdog_clear_instr_in) begin
						wclr_next = 1'b1;
						to_next = 1'b1;
						powerdown_next = 1'b1;
					end
					if (sleep_instr_in) begin
						fetch_next = pc_in + 16'h0001;
						if (wk.wake_req) begin
							// pending enabled flag: sleep becomes a nop
							nop_next = 1'b1;
							ev[`SWC_IRQ_NOP] = 1'b1;
						end else begin
							// watchdog cleared, flags updated, osc off
							wclr_next = 1'b1;
							to_next = 1'b1;
							powerdown_next = 1'b0;
							state_next = SWC_SLEEP;
							ev[`SWC_IRQ_ENTER] = 1'b1;
						end
					end
				end
				SWC_SLEEP: begin
					// sleep already done; a late interrupt wakes at once
					if (wk.wake_req) begin
						wdog_wake_next = 1'b0;
						state_next = SWC_STARTUP;
						ev[`SWC_IRQ_WAKE_INT] = 1'b1;
					end else if (watchdog_timeout_in &&
						ctrl_reg[`SWC_CTRL_WATCHDOG_EN]) begin
						to_next = 1'b0;
						wdog_wake_next = 1'b1;
						state_next = SWC_STARTUP;
						ev[`SWC_IRQ_WAKE_WATCHDOG] = 1'b1;
					end
					startup_cnt_next = 11'h000;
					if (state_next == SWC_STARTUP &&
						ctrl_reg[`SWC_CTRL_RC_MODE])
						state_next = SWC_RESUME;
				end
				SWC_STARTUP: begin
					// clock path stays off until the delay expires
					if (startup_cnt_reg == STARTUP_LAST)
						state_next = SWC_RESUME;
					else
						startup_cnt_next = startup_cnt_reg + 11'h001;
				end
				SWC_RESUME: begin
					// continuation, not a reset
					resume_next = 1'b1;
					vector_next = !wdog_wake_reg && ctrl_reg[`SWC_CTRL_IRQ_EN];
					if (vector_next)
						fetch_next = `SWC_VECTOR;
					state_next = SWC_RUN;
				end
			endcase
		end
		// pin-level status is registered off the next state, not decoded
		run_next = (state_next == SWC_RUN);
		osc_next = (state_next != SWC_SLEEP);
		hold_next = (state_next != SWC_RUN);
	end

	// axi4-lite slave and registers
	always_comb begin
		aw_next = aw_reg;
		awa_next = awa_reg;
		w_next = w_reg;
		wd_next = wd_reg;
		ws_next = ws_reg;
		bv_next = bv_reg;
		br_next = br_reg;
		rv_next = rv_reg;
		rr_next = rr_reg;
		rd_next = rd_reg;
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		irq_next = irq_reg;
		if (s_axi_awvalid && !aw_reg) begin
			aw_next = 1'b1;
			awa_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_reg) begin
			w_next = 1'b1;
			wd_next = s_axi_wdata;
			ws_next = s_axi_wstrb;
		end
		if (wr_go) begin
			aw_next = 1'b0;
			w_next = 1'b0;
			bv_next = 1'b1;
			br_next = okay_or_slverr(addr_hit(awa_reg));
			if (ctrl_wr && ws_reg[0])
				ctrl_next[7:0] = {5'h00, wd_reg[2:0]};
			if (awa_reg == `SWC_OFF_MASK && ws_reg[0])
				mask_next = wd_reg[3:0];
		end
		if (bv_reg && s_axi_bready)
			bv_next = 1'b0;
		if (rv_reg && s_axi_rready)
			rv_next = 1'b0;
		if (rd_go) begin
			rv_next = 1'b1;
			rr_next = okay_or_slverr(addr_hit(s_axi_araddr));
			rd_next = 32'h0000_0000;
			unique case (s_axi_araddr)
				`SWC_OFF_CTRL: rd_next = ctrl_reg;
				`SWC_OFF_STAT: rd_next = {28'h000_0000,
					state_reg == SWC_STARTUP, state_reg == SWC_SLEEP,
					powerdown_reg, to_reg};
				`SWC_OFF_IRQ: rd_next = {28'h000_0000, irq_reg};
				`SWC_OFF_MASK: rd_next = {28'h000_0000, mask_reg};
				`SWC_OFF_CNT: rd_next = {21'h00_0000, startup_cnt_reg};
				default: rd_next = 32'h0000_0000;
			endcase
			// read clears status; a same-cycle event still sets
			if (s_axi_araddr == `SWC_OFF_IRQ)
				irq_next = 4'h0;
		end
		irq_next = irq_next | ev;
		irq_out_next = |(irq_next & mask_reg);
		awrdy_next = !aw_next;
		wrdy_next = !w_next;
		ardy_next = !rv_next;
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state_reg <= SWC_RUN;
			startup_cnt_reg <= 11'h000;
			to_reg <= 1'b1;
			powerdown_reg <= 1'b1;
			wdog_wake_reg <= 1'b0;
			run_reg <= 1'b1;
			osc_reg <= 1'b1;
			hold_reg <= 1'b0;
			awrdy_reg <= 1'b1;
			wrdy_reg <= 1'b1;
			ardy_reg <= 1'b1;
			core_rst_reg <= 1'b1;
			wclr_reg <= 1'b0;
			nop_reg <= 1'b0;
			resume_reg <= 1'b0;
			vector_reg <= 1'b0;
			fetch_reg <= 16'h0000;
			ctrl_reg <= `SWC_CTRL_RESET;
			irq_reg <= 4'h0;
			mask_reg <= 4'h0;
			irq_out_reg <= 1'b0;
			aw_reg <= 1'b0;
			awa_reg <= 12'h000;
			w_reg <= 1'b0;
			wd_reg <= 32'h0000_0000;
			ws_reg <= 4'h0;
			bv_reg <= 1'b0;
			br_reg <= 2'h0;
			rv_reg <= 1'b0;
			rr_reg <= 2'h0;
			rd_reg <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			startup_cnt_reg <= startup_cnt_next;
			to_reg <= to_next;
			powerdown_reg <= powerdown_next;
			wdog_wake_reg <= wdog_wake_next;
			run_reg <= run_next;
			osc_reg <= osc_next;
			hold_reg <= hold_next;
			awrdy_reg <= awrdy_next;
			wrdy_reg <= wrdy_next;
			ardy_reg <= ardy_next;
			core_rst_reg <= core_rst_next;
			wclr_reg <= wclr_next;
			nop_reg <= nop_next;
			resume_reg <= resume_next;
			vector_reg <= vector_next;
			fetch_reg <= fetch_next;
			ctrl_reg <= ctrl_next;
			irq_reg <= irq_next;
			mask_reg <= mask_next;
			irq_out_reg <= irq_out_next;
			aw_reg <= aw_next;
			awa_reg <= awa_next;
			w_reg <= w_next;
			wd_reg <= wd_next;
			ws_reg <= ws_next;
			bv_reg <= bv_next;
			br_reg <= br_next;
			rv_reg <= rv_next;
			rr_reg <= rr_next;
			rd_reg <= rd_next;
		end
	end

	// clock off while asleep or starting, oscillator off only while asleep; pins held
	assign core_reset_out = core_rst_reg;
	assign clock_run_out = run_reg;
	assign osc_enable_out = osc_reg;
	assign io_hold_out = hold_reg;
	assign watchdog_clear_out = wclr_reg;
	assign sleep_nop_out = nop_reg;
	assign resume_out = resume_reg;
	assign vector_out = vector_reg;
	assign fetch_addr_out = fetch_reg;
	assign timeout_flag_out = to_reg;
	assign powerdown_flag_out = powerdown_reg;
	assign irq_out = irq_out_reg;
	assign s_axi_awready = awrdy_reg;
	assign s_axi_wready = wrdy_reg;
	assign s_axi_bvalid = bv_reg;
	assign s_axi_bresp = br_reg;
	assign s_axi_arready = ardy_reg;
	assign s_axi_rvalid = rv_reg;
	assign s_axi_rdata = rd_reg;
	assign s_axi_rresp = rr_reg;
endmodule

// >>> verif/swc_far_model.sv
// far-side model: sticky peripheral and pin flags, watchdog pulse.
// assumes the bench commands it by non-blocking writes at clock edges.
`timescale 1ns/10ps
module swc_far_model (
	// clock and reset
	input wire logic clock_in,
	input wire logic reset_in,
	// bench commands
	input wire logic [12:0] go_in,
	input wire logic clr_in,
	input wire logic wd_in,
	// events
	output swc_pkg::swc_src_t periph_flag_out,
	output logic int_pin_out,
	output logic port_chg_out,
	output logic timeout_out
);
	import swc_pkg::*;
	logic [12:0] flag_reg;
	// flags latch like real sources and stay up until software clears
	always_ff @(posedge clock_in) begin
		flag_reg <= (reset_in || clr_in) ? '0 : flag_reg | go_in;
		timeout_out <= wd_in && !reset_in;
	end
	assign periph_flag_out = flag_reg[10:0];
	assign int_pin_out = flag_reg[11];
	assign port_chg_out = flag_reg[12];
endmodule

// >>> verif/swc_checker.sv
// checker: sleep and wake sequencing seen at the top-level ports.
// assumes one clock domain; bound to swc_top at the foot of the file.
`timescale 1ns/10ps
module swc_checker (
	input wire logic clock_in, reset_in, sleep_instr_in,
	input wire swc_pkg::swc_pc_t pc_in, fetch_addr_out,
	input wire logic external_reset_pin_n_in, watchdog_timeout_in,
	input wire swc_pkg::swc_src_t periph_flag_in, periph_enable_in,
	input wire logic int_pin_flag_in, int_pin_enable_in,
	input wire logic port_b_change_in, port_b_change_enable_in,
	input wire logic core_reset_out, clock_run_out, osc_enable_out,
	input wire logic io_hold_out, watchdog_clear_out, sleep_nop_out,
	input wire logic vector_out, timeout_flag_out, powerdown_flag_out
);
	import swc_pkg::*;
	logic [10:0] wait_reg;
	wire pend = |(periph_flag_in & periph_enable_in) ||
		(int_pin_flag_in && int_pin_enable_in) ||
		(port_b_change_in && port_b_change_enable_in);
	wire take = sleep_instr_in && clock_run_out;
	wire wk = pend || watchdog_timeout_in || !external_reset_pin_n_in;
	// length of one oscillator-on, core-stopped stretch
	always_ff @(posedge clock_in)
		if (reset_in || clock_run_out || !osc_enable_out)
			wait_reg <= '0;
		else
			wait_reg <= wait_reg + 11'h001;
	default clocking @(posedge clock_in); endclocking
	default disable iff (reset_in);
	AST_ENTER: assert property (take && !pend |=>
		watchdog_clear_out && !powerdown_flag_out && timeout_flag_out)
		else $error("sleep entry flags wrong");
	AST_NOP: assert property (take && pend |=> sleep_nop_out &&
		!watchdog_clear_out && $stable(powerdown_flag_out))
		else $error("pending sleep not a no-op");
	AST_PREFETCH: assert property (take && !pend |=>
		fetch_addr_out == $past(pc_in) + 16'h0001)
		else $error("prefetch address wrong");
	AST_TIMEOUT: assert property ($fell(timeout_flag_out) |->
		$past(watchdog_timeout_in))
		else $error("timeout flag fell without watchdog");
	AST_HOLD: assert property (!osc_enable_out |->
		io_hold_out && !clock_run_out)
		else $error("asleep without hold");
	AST_ENTRY: assert property ($fell(osc_enable_out) |->
		watchdog_clear_out && $past(sleep_instr_in))
		else $error("sleep without instruction");
	AST_RST_PIN: assert property (!external_reset_pin_n_in |=>
		core_reset_out)
		else $error("reset pin ignored");
	AST_WAKE: assert property ($rose(osc_enable_out) |->
		$past(wk) || $past(wk, 2) || $past(wk, 3))
		else $error("wake without enabled cause");
	AST_STARTUP: assert property (wait_reg <= 11'h410)
		else $error("startup stretch too long");
	CVR_NOP: cover property (sleep_nop_out);
	CVR_VECTOR: cover property (vector_out);
	CVR_WDT: cover property ($fell(timeout_flag_out));
endmodule
bind swc_top swc_checker u_chk (
	.clock_in(clock_in),
	.reset_in(reset_in),
	.sleep_instr_in(sleep_instr_in),
	.pc_in(pc_in),
	.fetch_addr_out(fetch_addr_out),
	.external_reset_pin_n_in(external_reset_pin_n_in),
	.watchdog_timeout_in(watchdog_timeout_in),
	.periph_flag_in(periph_flag_in),
	.periph_enable_in(periph_enable_in),
	.int_pin_flag_in(int_pin_flag_in),
	.int_pin_enable_in(int_pin_enable_in),
	.port_b_change_in(port_b_change_in),
	.port_b_change_enable_in(port_b_change_enable_in),
	.core_reset_out(core_reset_out),
	.clock_run_out(clock_run_out),
	.osc_enable_out(osc_enable_out),
	.io_hold_out(io_hold_out),
	.watchdog_clear_out(watchdog_clear_out),
	.sleep_nop_out(sleep_nop_out),
	.vector_out(vector_out),
	.timeout_flag_out(timeout_flag_out),
	.powerdown_flag_out(powerdown_flag_out)
);

// >>> verif/sleep_wakeup_control_tb.sv
// bench: axi4-lite master, random naps and corner cases, self-checking.
// assumes the design, the far-side model and the checker are compiled.
`timescale 1ns/10ps
`include "swc_params.svh"
module sleep_wakeup_control_tb;
	import swc_pkg::*;
	logic clock_in, reset_in, sleep_instr_in, watchdog_clear_instr_in;
	logic external_reset_pin_n_in, watchdog_timeout_in;
	logic int_pin_flag_in, port_b_change_in, irq_out;
	logic core_reset_out, clock_run_out, osc_enable_out, io_hold_out;
	logic watchdog_clear_out, sleep_nop_out, resume_out, vector_out;
	logic timeout_flag_out, powerdown_flag_out;
	swc_pc_t pc_in, fetch_addr_out;
	swc_src_t periph_flag_in;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, clr, wd_fire;
	logic [12:0] go, en;
	logic [7:0] rnd;
	int mismatches, checked;
	wire swc_src_t periph_enable_in = en[10:0];
	wire logic int_pin_enable_in = en[11];
	wire logic port_b_change_enable_in = en[12];
	swc_top dut (.*);
	swc_far_model far (.clock_in, .reset_in, .go_in(go), .clr_in(clr),
		.wd_in(wd_fire), .periph_flag_out(periph_flag_in),
		.int_pin_out(int_pin_flag_in), .port_chg_out(port_b_change_in),
		.timeout_out(watchdog_timeout_in));
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic swc_pc_t exp_fetch(input swc_pc_t p, input logic v);
		return v ? swc_pc_t'(`SWC_VECTOR) : p + 16'h0001;
	endfunction
	task automatic chk(input string nm, input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		if (mismatches == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		logic ad = 1'b0;
		logic wdn = 1'b0;
		@(posedge clock_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock_in);
			ad = ad || s_axi_awready;
			wdn = wdn || s_axi_wready;
			s_axi_awvalid <= !ad;
			s_axi_wvalid <= !wdn;
		end while (!(ad && wdn));
		while (!s_axi_bvalid) @(posedge clock_in);
		chk("bresp", s_axi_bresp, 0);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clock_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clock_in); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge clock_in);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (a != 12'h0FC) chk("rdata", d, e);
		chk("rresp", r, (a == 12'h0FC) ? 2 : 0);
	endtask
	// one sleep, one wake event, then the resume checks
	task automatic nap(input logic [12:0] src, input logic wd, vec,
		input int lo, hi, input logic mute);
		int n = 0;
		swc_pc_t p = {rnd, ~rnd};
		pc_in <= p;
		sleep_instr_in <= 1'b1;
		@(posedge clock_in);
		sleep_instr_in <= 1'b0;
		#1;
		chk("enter", watchdog_clear_out, 1);
		chk("powerdown", powerdown_flag_out, 0);
		chk("fetch", fetch_addr_out, p + 16'h0001);
		chk("hold", io_hold_out, 1);
		@(posedge clock_in);
		go <= src;
		wd_fire <= wd;
		if (mute) en <= en & ~src;
		@(posedge clock_in);
		go <= '0;
		wd_fire <= 1'b0;
		if (mute) begin
			repeat (30) @(posedge clock_in);
			chk("muted", osc_enable_out, 0);
			en <= '1;
		end
		do begin
			@(posedge clock_in);
			n++;
		end while (!resume_out && n < 3000);
		chk("startup", 32'(n >= lo && n <= hi), 1);
		chk("vector", vector_out, vec);
		chk("resume", fetch_addr_out, exp_fetch(p, vec));
		chk("run", clock_run_out, 1);
		chk("noreset", core_reset_out, 0);
		chk("to", timeout_flag_out, !wd);
		clr <= 1'b1;
		@(posedge clock_in);
		clr <= 1'b0;
	endtask
	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end
	// a full pass needs about 10k cycles, under half a millisecond
	initial begin
		#2_000_000;
		mismatches++;
		tally_and_finish;
	end
	initial begin
		{sleep_instr_in, watchdog_clear_instr_in, clr, wd_fire} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, pc_in, go} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{reset_in, external_reset_pin_n_in} = 2'h3;
		{en, s_axi_wstrb, rnd} = {13'h1FFF, 4'hF, 8'h27};
		repeat (2) @(posedge clock_in);
		reset_in <= 1'b0;
		rd(`SWC_OFF_STAT, 32'h0000_0003);
		rd(12'h0FC, 0);
		chk("slverr", r, 2'h2);
		wr(`SWC_OFF_MASK, 32'h0000_000F);
		wr(`SWC_OFF_CTRL, 32'h0000_0005);
		go <= 13'h0004;
		@(posedge clock_in);
		go <= '0;
		@(posedge clock_in);
		sleep_instr_in <= 1'b1;
		@(posedge clock_in);
		sleep_instr_in <= 1'b0;
		#1;
		chk("nop", sleep_nop_out, 1);
		chk("pdkept", powerdown_flag_out, 1);
		chk("wdkept", watchdog_clear_out, 0);
		repeat (3) @(posedge clock_in);
		chk("irq", irq_out, 1);
		rd(`SWC_OFF_IRQ, 32'h0000_0002);
		clr <= 1'b1;
		@(posedge clock_in);
		clr <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			nap(13'h0001 << (rnd % 13), 0, 1, 1024, 1040, rnd[0]);
		end
		wr(`SWC_OFF_CTRL, 32'h0000_0001);
		nap(13'h0800, 0, 0, 1024, 1040, 0);
		nap(13'h0000, 1, 0, 1024, 1040, 0);
		watchdog_clear_instr_in <= 1'b1;
		@(posedge clock_in);
		watchdog_clear_instr_in <= 1'b0;
		repeat (2) @(posedge clock_in);
		chk("wdclear", {timeout_flag_out, powerdown_flag_out}, 2'h3);
		rd(`SWC_OFF_IRQ, 32'h0000_000D);
		wr(`SWC_OFF_CTRL, 32'h0000_0003);
		wr(`SWC_OFF_MASK, 32'h0000_0000);
		nap(13'h1000, 0, 0, 1, 16, 0);
		chk("masked", irq_out, 0);
		rd(`SWC_OFF_IRQ, 32'h0000_0005);
		// watchdog disabled: its time-out must not wake the core
		wr(`SWC_OFF_CTRL, 32'h0000_0002);
		sleep_instr_in <= 1'b1;
		@(posedge clock_in);
		sleep_instr_in <= 1'b0;
		wd_fire <= 1'b1;
		@(posedge clock_in);
		wd_fire <= 1'b0;
		repeat (4) @(posedge clock_in);
		chk("wdoff", osc_enable_out, 0);
		external_reset_pin_n_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		chk("corereset", core_reset_out, 1);
		external_reset_pin_n_in <= 1'b1;
		repeat (1200) @(posedge clock_in);
		chk("awake", {clock_run_out, core_reset_out}, 2'h2);
		tally_and_finish;
	end
endmodule
